/* hw/tcd_chan_req.sv */
// Per-channel cause decoder and pending request latch
`timescale 1ns/1ps
module tcd_chan_req
  import tcd_pkg::*;
#(
  parameter int CH = 0
) (
  input  wire logic              ref_clk_in,
  input  wire logic              rst_in,
  input  wire logic [SRC_W-1:0]  src_vec_in,
  input  wire logic              bank_in,
  input  wire logic [CODE_W-1:0] code_in,
  input  wire logic              sw_req_in,
  input  wire logic              enable_in,
  input  wire logic              take_in,
  output logic                   pending_out
);

  if (CH < 0 || CH > 1) begin : g_bad_ch
    $error("Channel number must be 0 or 1");
  end

  typedef struct packed {
    logic pend;
  } tcd_req_st_t;

  tcd_req_st_t  r;
  tcd_req_st_t  d;
  tcd_src_idx_t idx;
  logic         hit;

  always_comb begin
    idx   = CAUSE_MAP[CH][bank_in][code_in];
    hit   = (idx == SRC_SW) ? sw_req_in : src_vec_in[idx];
    d     = r;
    // Set wins over take; no count kept, repeats merge
    d.pend = enable_in & (hit | (r.pend & ~take_in));
  end

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      r <= '0;
    end else begin
      r <= d;
    end
  end

  assign pending_out = r.pend;

  property p_sw_raise;
    @(posedge ref_clk_in) disable iff (rst_in)
      (sw_req_in && enable_in && !bank_in && CAUSE_MAP[CH][0][code_in] == SRC_SW)
      |=> pending_out;
  endproperty
  a_sw_raise: assert property (p_sw_raise) else $error("Software request lost");

  property p_off_idle;
    @(posedge ref_clk_in) disable iff (rst_in)
      !enable_in |=> !pending_out;
  endproperty
  a_off_idle: assert property (p_off_idle) else $error("Request held while off");

endmodule : tcd_chan_req

/* hw/tcd_dma.sv */
// Two-channel cycle-steal transfer engine with AXI4-Lite register slave
//
// The implementer's own choices: the AXI4-Lite register port and the register offsets.
`timescale 1ns/1ps
module tcd_dma
  import tcd_pkg::*;
(
  input  wire logic              ref_clk_in,
  input  wire logic              rst_in,
  input  wire logic [AXI_AW-1:0] s_axi_awaddr_in,
  input  wire logic              s_axi_awvalid_in,
  output logic                   s_axi_awready_out,
  input  wire logic [31:0]       s_axi_wdata_in,
  input  wire logic [3:0]        s_axi_wstrb_in,
  input  wire logic              s_axi_wvalid_in,
  output logic                   s_axi_wready_out,
  output logic [1:0]             s_axi_bresp_out,
  output logic                   s_axi_bvalid_out,
  input  wire logic              s_axi_bready_in,
  input  wire logic [AXI_AW-1:0] s_axi_araddr_in,
  input  wire logic              s_axi_arvalid_in,
  output logic                   s_axi_arready_out,
  output logic [31:0]            s_axi_rdata_out,
  output logic [1:0]             s_axi_rresp_out,
  output logic                   s_axi_rvalid_out,
  input  wire logic              s_axi_rready_in,
  input  wire logic              external_irq_line_zero_in,
  input  wire logic              external_irq_line_one_in,
  input  wire logic [4:0]        timer_a_irq_in,
  input  wire logic [2:0]        timer_b_irq_in,
  input  wire logic [2:0]        uart_tx_irq_in,
  input  wire logic [2:0]        uart_rx_irq_in,
  input  wire logic              sync_serial_port_three_irq_in,
  input  wire logic              sync_serial_port_four_irq_in,
  input  wire logic              adc_irq_in,
  input  wire logic [8:0]        capture_compare_timer_irq_in,
  output logic                   bus_req_out,
  input  wire logic              bus_grant_in,
  output logic [ADDR_W-1:0]      bus_addr_out,
  output logic                   bus_rd_out,
  output logic                   bus_wr_out,
  output logic                   bus_word_out,
  output logic [15:0]            bus_wdata_out,
  input  wire logic [15:0]       bus_rdata_in,
  input  wire logic              bus_ack_in
);

  typedef struct packed {
    tcd_state_t              st;
    logic                    cur;
    logic [1:0]              en;
    logic [1:0]              w16;
    logic [1:0]              rpt;
    logic [1:0]              sinc;
    logic [1:0]              dinc;
    logic [1:0]              first;
    logic [1:0]              bank;
    logic [1:0]              sw;
    logic [1:0][CODE_W-1:0]  code;
    logic [1:0][ADDR_W-1:0]  sp;
    logic [1:0][ADDR_W-1:0]  dp;
    logic [1:0][ADDR_W-1:0]  ptr;
    logic [1:0][CNT_W-1:0]   rld;
    logic [1:0][CNT_W-1:0]   cnt;
    logic                    req;
    logic                    rd;
    logic                    wr;
    logic                    word;
    logic [ADDR_W-1:0]       addr;
    logic [15:0]             wdata;
    logic [1:0]              irq_s1;
    logic [1:0]              irq_s2;
    logic [1:0]              irq_p;
    logic                    awrdy;
    logic                    wrdy;
    logic                    aw_h;
    logic                    w_h;
    logic [AXI_AW-1:0]       awa;
    logic [31:0]             wd;
    logic [3:0]              ws;
    logic                    bval;
    logic [1:0]              bresp;
    logic                    arrdy;
    logic                    rval;
    logic [31:0]             rdat;
    logic [1:0]              rresp;
  } tcd_st_t;

  tcd_st_t           r;
  tcd_st_t           d;
  logic [1:0]        pend;
  logic [1:0]        take;
  logic [SRC_W-1:0]  src_vec;
  logic [1:0]        irq_fall;
  logic [1:0]        irq_both;
  logic              sel;
  logic [ADDR_W-1:0] step;

  // Edges of the synchronised external lines
  assign irq_fall = r.irq_p & ~r.irq_s2;
  assign irq_both = r.irq_p ^ r.irq_s2;
  assign sel      = pend[0] ? 1'b0 : 1'b1;
  assign step     = r.w16[r.cur] ? STEP_WORD : STEP_BYTE;

  // Source vector; interrupt sources feed only requests, never flags
  assign src_vec = {capture_compare_timer_irq_in, adc_irq_in,
                    sync_serial_port_four_irq_in, sync_serial_port_three_irq_in,
                    uart_rx_irq_in[2], uart_tx_irq_in[2], uart_rx_irq_in[1],
                    uart_tx_irq_in[1], uart_rx_irq_in[0], uart_tx_irq_in[0],
                    timer_b_irq_in, timer_a_irq_in, 1'b0,
                    irq_both[1], irq_fall[1], irq_both[0], irq_fall[0], 1'b0};

  for (genvar g = 0; g < 2; g++) begin : g_ch
    tcd_chan_req #(
      .CH (g)
    ) u_req (
      .ref_clk_in  (ref_clk_in),
      .rst_in      (rst_in),
      .src_vec_in  (src_vec),
      .bank_in     (r.bank[g]),
      .code_in     (r.code[g]),
      .sw_req_in   (r.sw[g]),
      .enable_in   (r.en[g]),
      .take_in     (take[g]),
      .pending_out (pend[g])
    );
  end

  function automatic logic [32:0] reg_read(input logic [AXI_AW-1:0] a);
    logic [31:0] v;
    logic        ok;
    logic        c;
    v  = '0;
    ok = 1'b1;
    c  = a[CH_BIT];
    if (a[7:6] != BLK_TOP) begin
      ok = 1'b0;
    end else begin
      unique case (a & OFF_MASK)
        OFF_CTRL: begin
          v[CTRL_EN]   = r.en[c];
          v[CTRL_W16]  = r.w16[c];
          v[CTRL_RPT]  = r.rpt[c];
          v[CTRL_SINC] = r.sinc[c];
          v[CTRL_DINC] = r.dinc[c];
          v[CTRL_PEND] = pend[c];
        end
        OFF_SEL: begin
          v[SEL_CODE_LSB +: CODE_W] = r.code[c];
          v[SEL_BANK]               = r.bank[c];
        end
        OFF_SRC:    v[ADDR_W-1:0] = r.sp[c];
        OFF_DST:    v[ADDR_W-1:0] = r.dp[c];
        OFF_RELOAD: v[CNT_W-1:0]  = r.rld[c];
        OFF_COUNT:  v[CNT_W-1:0]  = r.cnt[c];
        OFF_PTR:    v[ADDR_W-1:0] = r.ptr[c];
        default:    ok = 1'b0;
      endcase
    end
    return {ok, v};
  endfunction : reg_read

  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
                                        input logic [3:0] s);
    logic [31:0] m;
    m = o;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) begin
        m[i*8 +: 8] = n[i*8 +: 8];
      end
    end
    return m;
  endfunction : merge

  always_comb begin
    logic [32:0]       rr;
    logic [31:0]       nv;
    logic              wc;
    logic [ADDR_W-1:0] sa;
    logic [ADDR_W-1:0] da;
    rr = '0;
    nv = '0;
    wc = 1'b0;
    sa = '0;
    da = '0;
    d  = r;
    take     = 2'b00;
    d.sw     = 2'b00;
    d.irq_s1 = {external_irq_line_one_in, external_irq_line_zero_in};
    d.irq_s2 = r.irq_s1;
    d.irq_p  = r.irq_s2;
    // Source prefers the incrementing pointer if both are set
    sa = r.sinc[r.cur] ? r.ptr[r.cur] : r.sp[r.cur];
    da = (r.dinc[r.cur] && !r.sinc[r.cur]) ? r.ptr[r.cur] : r.dp[r.cur];

    unique case (r.st)
      S_IDLE: begin
        if (pend != 2'b00) begin
          d.cur     = sel;
          take[sel] = 1'b1;
          d.req     = 1'b1;
          d.st      = S_REQ;
          if (r.first[sel]) begin
            d.ptr[sel]   = r.sinc[sel] ? r.sp[sel] : r.dp[sel];
            d.cnt[sel]   = r.rld[sel];
            d.first[sel] = 1'b0;
          end
        end
      end
      S_REQ: begin
        if (bus_grant_in) begin
          d.rd   = 1'b1;
          d.addr = sa;
          d.word = r.w16[r.cur];
          d.st   = S_RD;
        end
      end
      S_RD: begin
        if (bus_ack_in) begin
          d.rd    = 1'b0;
          d.wr    = 1'b1;
          d.addr  = da;
          d.wdata = r.w16[r.cur] ? bus_rdata_in : {BYTE_ZERO, bus_rdata_in[7:0]};
          d.st    = S_WR;
        end
      end
      S_WR: begin
        if (bus_ack_in) begin
          d.wr  = 1'b0;
          d.req = 1'b0;
          d.st  = S_IDLE;
          if (r.sinc[r.cur] || r.dinc[r.cur]) begin
            d.ptr[r.cur] = r.ptr[r.cur] + step;
          end
          if (r.cnt[r.cur] == CNT_RST) begin
            if (r.rpt[r.cur]) begin
              d.cnt[r.cur] = r.rld[r.cur];
            end else begin
              d.en[r.cur] = 1'b0;
            end
          end else begin
            d.cnt[r.cur] = r.cnt[r.cur] - 16'h0001;
          end
        end
      end
    endcase

    // Write channel: address and data taken in either order
    if (r.awrdy && s_axi_awvalid_in) begin
      d.awrdy = 1'b0;
      d.aw_h  = 1'b1;
      d.awa   = s_axi_awaddr_in;
    end
    if (r.wrdy && s_axi_wvalid_in) begin
      d.wrdy = 1'b0;
      d.w_h  = 1'b1;
      d.wd   = s_axi_wdata_in;
      d.ws   = s_axi_wstrb_in;
    end
    if (r.aw_h && r.w_h && !r.bval) begin
      rr      = reg_read(r.awa);
      nv      = merge(rr[31:0], r.wd, r.ws);
      wc      = r.awa[CH_BIT];
      d.aw_h  = 1'b0;
      d.w_h   = 1'b0;
      d.bval  = 1'b1;
      d.bresp = rr[32] ? RESP_OKAY : RESP_SLVERR;
      if (rr[32]) begin
        unique case (r.awa & OFF_MASK)
          OFF_CTRL: begin
            d.en[wc]    = nv[CTRL_EN];
            d.first[wc] = (nv[CTRL_EN] && !r.en[wc]) ? 1'b1 : d.first[wc];
            d.w16[wc]   = nv[CTRL_W16];
            d.rpt[wc]   = nv[CTRL_RPT];
            d.sinc[wc]  = nv[CTRL_SINC];
            d.dinc[wc]  = nv[CTRL_DINC];
          end
          OFF_SEL: begin
            d.code[wc] = nv[SEL_CODE_LSB +: CODE_W];
            d.bank[wc] = nv[SEL_BANK];
            d.sw[wc]   = r.ws[0] & r.wd[SEL_SWREQ];
          end
          OFF_SRC:    d.sp[wc]  = nv[ADDR_W-1:0];
          OFF_DST:    d.dp[wc]  = nv[ADDR_W-1:0];
          OFF_RELOAD: d.rld[wc] = nv[CNT_W-1:0];
          default: begin
          end
        endcase
      end
    end
    if (r.bval && s_axi_bready_in) begin
      d.bval  = 1'b0;
      d.awrdy = 1'b1;
      d.wrdy  = 1'b1;
    end

    // Read channel
    if (r.arrdy && s_axi_arvalid_in) begin
      rr      = reg_read(s_axi_araddr_in);
      d.arrdy = 1'b0;
      d.rval  = 1'b1;
      d.rdat  = rr[31:0];
      d.rresp = rr[32] ? RESP_OKAY : RESP_SLVERR;
    end
    if (r.rval && s_axi_rready_in) begin
      d.rval  = 1'b0;
      d.arrdy = 1'b1;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      r       <= '0;
      r.st    <= S_IDLE;
      r.awrdy <= 1'b1;
      r.wrdy  <= 1'b1;
      r.arrdy <= 1'b1;
      // External lines idle high; no false edge after reset
      r.irq_s1 <= '1;
      r.irq_s2 <= '1;
      r.irq_p  <= '1;
    end else begin
      r <= d;
    end
  end

  assign s_axi_awready_out = r.awrdy;
  assign s_axi_wready_out  = r.wrdy;
  assign s_axi_bresp_out   = r.bresp;
  assign s_axi_bvalid_out  = r.bval;
  assign s_axi_arready_out = r.arrdy;
  assign s_axi_rdata_out   = r.rdat;
  assign s_axi_rresp_out   = r.rresp;
  assign s_axi_rvalid_out  = r.rval;
  assign bus_req_out       = r.req;
  assign bus_addr_out      = r.addr;
  assign bus_rd_out        = r.rd;
  assign bus_wr_out        = r.wr;
  assign bus_word_out      = r.word;
  assign bus_wdata_out     = r.wdata;

  property p_steal;
    @(posedge ref_clk_in) disable iff (rst_in)
      (r.st == S_WR && bus_ack_in) |=> !bus_req_out && !bus_wr_out;
  endproperty
  a_steal: assert property (p_steal) else $error("Bus kept after one transfer");

  property p_prio;
    @(posedge ref_clk_in) disable iff (rst_in)
      (r.st == S_IDLE && pend == 2'b11) |=> (r.cur == 1'b0) && bus_req_out;
  endproperty
  a_prio: assert property (p_prio) else $error("Channel one granted first");

  property p_rdwr;
    @(posedge ref_clk_in) disable iff (rst_in)
      (r.st == S_RD && bus_ack_in) |=> bus_wr_out && !bus_rd_out
        && bus_wdata_out[7:0] == $past(bus_rdata_in[7:0]);
  endproperty
  a_rdwr: assert property (p_rdwr) else $error("Write does not follow read");

  property p_incr;
    @(posedge ref_clk_in) disable iff (rst_in)
      (r.st == S_WR && bus_ack_in && (r.sinc[r.cur] || r.dinc[r.cur]))
      |=> r.ptr[r.cur] == $past(r.ptr[r.cur]) + $past(step);
  endproperty
  a_incr: assert property (p_incr) else $error("Pointer step wrong");

  property p_dec;
    @(posedge ref_clk_in) disable iff (rst_in)
      (r.st == S_WR && bus_ack_in && r.cnt[r.cur] != CNT_RST)
      |=> r.cnt[r.cur] == $past(r.cnt[r.cur]) - 16'h0001;
  endproperty
  a_dec: assert property (p_dec) else $error("Counter not decremented");

  property p_single_stop;
    @(posedge ref_clk_in) disable iff (rst_in)
      (r.st == S_WR && bus_ack_in && !r.rpt[r.cur] && r.cnt[r.cur] == CNT_RST
       && !(r.aw_h && r.w_h && !r.bval))
      |=> !r.en[r.cur] ##1 !pend[r.cur];
  endproperty
  a_single_stop: assert property (p_single_stop) else $error("Single run kept going");

  property p_repeat;
    @(posedge ref_clk_in) disable iff (rst_in)
      (r.st == S_WR && bus_ack_in && r.rpt[r.cur] && r.cnt[r.cur] == CNT_RST
       && !(r.aw_h && r.w_h && !r.bval))
      |=> r.cnt[r.cur] == $past(r.rld[r.cur]) && r.en[r.cur] == $past(r.en[r.cur]);
  endproperty
  a_repeat: assert property (p_repeat) else $error("Repeat reload missed");

  property p_first;
    @(posedge ref_clk_in) disable iff (rst_in)
      (r.st == S_IDLE && pend != 2'b00 && r.first[sel])
      |=> r.cnt[r.cur] == $past(r.rld[sel]) && !r.first[r.cur]
        && r.ptr[r.cur] == (r.sinc[r.cur] ? $past(r.sp[sel]) : $past(r.dp[sel]));
  endproperty
  a_first: assert property (p_first) else $error("First transfer reload missed");

endmodule : tcd_dma

/* hw/tcd_pkg.sv */
// Constants, register map and cause tables for the two-channel cycle-steal mover
package tcd_pkg;

  localparam int ADDR_W = 20;
  localparam int CNT_W  = 16;
  localparam int CODE_W = 4;
  localparam int SRC_W  = 32;
  localparam int AXI_AW = 8;

  // Register map, one block of eight words per channel
  localparam int         CH_BIT     = 5;
  localparam logic [7:0] OFF_MASK   = 8'h1F;
  localparam logic [1:0] BLK_TOP    = 2'h0;
  localparam logic [7:0] OFF_CTRL   = 8'h00;
  localparam logic [7:0] OFF_SEL    = 8'h04;
  localparam logic [7:0] OFF_SRC    = 8'h08;
  localparam logic [7:0] OFF_DST    = 8'h0C;
  localparam logic [7:0] OFF_RELOAD = 8'h10;
  localparam logic [7:0] OFF_COUNT  = 8'h14;
  localparam logic [7:0] OFF_PTR    = 8'h18;

  // Control register fields
  localparam int CTRL_EN   = 0;
  localparam int CTRL_W16  = 1;
  localparam int CTRL_RPT  = 2;
  localparam int CTRL_SINC = 4;
  localparam int CTRL_DINC = 5;
  localparam int CTRL_PEND = 7;

  // Cause select register fields
  localparam int SEL_CODE_LSB = 0;
  localparam int SEL_BANK     = 6;
  localparam int SEL_SWREQ    = 7;

  localparam logic [1:0]        RESP_OKAY   = 2'h0;
  localparam logic [1:0]        RESP_SLVERR = 2'h2;
  localparam logic [ADDR_W-1:0] PTR_RST     = 20'h00000;
  localparam logic [CNT_W-1:0]  CNT_RST     = 16'h0000;
  localparam logic [ADDR_W-1:0] STEP_BYTE   = 20'h00001;
  localparam logic [ADDR_W-1:0] STEP_WORD   = 20'h00002;
  localparam logic [7:0]        BYTE_ZERO   = 8'h00;

  typedef logic [4:0] tcd_src_idx_t;

  // Request source positions in the source vector
  localparam tcd_src_idx_t SRC_NONE = 5'h00;
  localparam tcd_src_idx_t SRC_SW   = 5'h05;

  // Cause code to source, indexed [channel][bank][code]
  localparam tcd_src_idx_t CAUSE_MAP [2][2][16] = '{
    '{'{5'h01, 5'h05, 5'h06, 5'h07, 5'h08, 5'h09, 5'h0A, 5'h0B,
        5'h0C, 5'h0D, 5'h0E, 5'h0F, 5'h12, 5'h13, 5'h16, 5'h10},
      '{5'h17, 5'h00, 5'h18, 5'h19, 5'h00, 5'h00, 5'h02, 5'h00,
        5'h00, 5'h00, 5'h1A, 5'h1B, 5'h1C, 5'h1D, 5'h1E, 5'h1F}},
    '{'{5'h03, 5'h05, 5'h06, 5'h07, 5'h08, 5'h09, 5'h0A, 5'h0B,
        5'h0C, 5'h0D, 5'h14, 5'h15, 5'h11, 5'h12, 5'h16, 5'h10},
      '{5'h17, 5'h00, 5'h18, 5'h19, 5'h00, 5'h00, 5'h04, 5'h00,
        5'h00, 5'h00, 5'h1A, 5'h1B, 5'h1C, 5'h1D, 5'h1E, 5'h1F}}};

  typedef enum logic [1:0] {S_IDLE, S_REQ, S_RD, S_WR} tcd_state_t;

endpackage : tcd_pkg

/* testbench/tb_top.sv */
// Self-checking bench for the two-channel cycle-steal mover
`timescale 1ns/1ps
`define CHK(nm, ex, got) \
  begin \
    samples_checked++; \
    if ((got) !== (ex)) begin \
      err_total++; \
      $display("ERROR %s expected %0h seen %0h", nm, ex, got); \
    end \
  end
module tb_top;
  import tcd_pkg::*;
  logic ref_clk_in, rst_in, s_axi_awvalid_in, s_axi_awready_out, s_axi_wvalid_in;
  logic s_axi_wready_out, s_axi_bvalid_out, s_axi_bready_in, s_axi_arvalid_in;
  logic s_axi_arready_out, s_axi_rvalid_out, s_axi_rready_in, adc_irq_in;
  logic external_irq_line_zero_in, external_irq_line_one_in, bus_req_out, bus_grant_in;
  logic sync_serial_port_three_irq_in, sync_serial_port_four_irq_in, bus_ack_in;
  logic bus_rd_out, bus_wr_out, bus_word_out;
  logic [7:0]  s_axi_awaddr_in, s_axi_araddr_in;
  logic [31:0] s_axi_wdata_in, s_axi_rdata_out;
  logic [3:0]  s_axi_wstrb_in, lag;
  logic [1:0]  s_axi_bresp_out, s_axi_rresp_out;
  logic [4:0]  timer_a_irq_in;
  logic [2:0]  timer_b_irq_in, uart_tx_irq_in, uart_rx_irq_in;
  logic [8:0]  capture_compare_timer_irq_in;
  logic [19:0] bus_addr_out;
  logic [15:0] bus_wdata_out, bus_rdata_in;
  int          err_total, samples_checked, cyc;
  logic        rd_word;

  // Unit size seen on the last acknowledged read
  always @(posedge ref_clk_in) begin
    if (bus_rd_out && bus_ack_in) begin
      rd_word <= bus_word_out;
    end
  end

  tcd_dma DUT (.ref_clk_in, .rst_in, .s_axi_awaddr_in, .s_axi_awvalid_in, .s_axi_awready_out,
    .s_axi_wdata_in, .s_axi_wstrb_in, .s_axi_wvalid_in, .s_axi_wready_out, .s_axi_bresp_out,
    .s_axi_bvalid_out, .s_axi_bready_in, .s_axi_araddr_in, .s_axi_arvalid_in,
    .s_axi_arready_out, .s_axi_rdata_out, .s_axi_rresp_out, .s_axi_rvalid_out,
    .s_axi_rready_in, .external_irq_line_zero_in, .external_irq_line_one_in, .timer_a_irq_in,
    .timer_b_irq_in, .uart_tx_irq_in, .uart_rx_irq_in, .sync_serial_port_three_irq_in,
    .sync_serial_port_four_irq_in, .adc_irq_in, .capture_compare_timer_irq_in, .bus_req_out,
    .bus_grant_in, .bus_addr_out, .bus_rd_out, .bus_wr_out, .bus_word_out, .bus_wdata_out,
    .bus_rdata_in, .bus_ack_in);

  tcd_bus_model mem (.ref_clk_in, .rst_in, .lag_in(lag), .bus_req_in(bus_req_out),
    .bus_grant_out(bus_grant_in), .bus_addr_in(bus_addr_out), .bus_rd_in(bus_rd_out),
    .bus_wr_in(bus_wr_out), .bus_wdata_in(bus_wdata_out), .bus_rdata_out(bus_rdata_in),
    .bus_ack_out(bus_ack_in));

  function automatic logic [15:0] pat(input logic [19:0] a);
    return {~a[7:0], a[7:0]};
  endfunction : pat

  task automatic results;
    if (err_total == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : results

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ad, wd;
    ad = 1'b0;
    wd = 1'b0;
    @(posedge ref_clk_in);
    s_axi_awaddr_in <= a;
    s_axi_wdata_in <= d;
    s_axi_awvalid_in <= 1'b1;
    s_axi_wvalid_in <= 1'b1;
    while (!(ad && wd)) begin
      @(posedge ref_clk_in);
      if (s_axi_awvalid_in && s_axi_awready_out) begin
        ad = 1'b1;
        s_axi_awvalid_in <= 1'b0;
      end
      if (s_axi_wvalid_in && s_axi_wready_out) begin
        wd = 1'b1;
        s_axi_wvalid_in <= 1'b0;
      end
    end
    s_axi_bready_in <= 1'b1;
    do @(posedge ref_clk_in); while (s_axi_bvalid_out !== 1'b1);
    s_axi_bready_in <= 1'b0;
    `CHK("bresp", er, s_axi_bresp_out)
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    @(posedge ref_clk_in);
    s_axi_araddr_in <= a;
    s_axi_arvalid_in <= 1'b1;
    s_axi_rready_in <= 1'b1;
    do @(posedge ref_clk_in); while (s_axi_arready_out !== 1'b1);
    s_axi_arvalid_in <= 1'b0;
    do @(posedge ref_clk_in); while (s_axi_rvalid_out !== 1'b1);
    s_axi_rready_in <= 1'b0;
    `CHK("rdata", ed, s_axi_rdata_out)
    `CHK("rresp", er, s_axi_rresp_out)
  endtask : axi_rd

  task automatic cfg(input logic [7:0] b, input logic [31:0] s, d, r, sl, c);
    axi_wr(b | OFF_SRC, s, RESP_OKAY);
    axi_wr(b | OFF_DST, d, RESP_OKAY);
    axi_wr(b | OFF_RELOAD, r, RESP_OKAY);
    axi_wr(b | OFF_SEL, sl, RESP_OKAY);
    axi_wr(b | OFF_CTRL, c, RESP_OKAY);
  endtask : cfg

  task automatic pulse(input int which);
    @(posedge ref_clk_in);
    if (which == 0) timer_a_irq_in <= 5'h01;
    if (which == 1) sync_serial_port_three_irq_in <= 1'b1;
    if (which == 2) uart_tx_irq_in <= 3'h1;
    @(posedge ref_clk_in);
    timer_a_irq_in <= 5'h00;
    sync_serial_port_three_irq_in <= 1'b0;
    uart_tx_irq_in <= 3'h0;
  endtask : pulse

  task automatic wait_wr(input int n);
    for (int k = 0; k < 300 && mem.wr_cnt < n; k++) @(posedge ref_clk_in);
    repeat (20) @(posedge ref_clk_in);
    `CHK("writes", n, mem.wr_cnt)
  endtask : wait_wr

  task automatic s_regs;
    axi_rd(OFF_CTRL, 32'h00000000, RESP_OKAY);
    axi_wr(OFF_SRC, 32'hFFFFFFFF, RESP_OKAY);
    axi_rd(OFF_SRC, 32'h000FFFFF, RESP_OKAY);
    axi_wr(OFF_COUNT, 32'h00000005, RESP_OKAY);
    axi_rd(OFF_COUNT, 32'h00000000, RESP_OKAY);
    axi_wr(8'h1C, 32'h00000001, RESP_SLVERR);
    axi_rd(8'h40, 32'h00000000, RESP_SLVERR);
  endtask : s_regs

  task automatic s_single;
    // Source-only increment, word units, three units per run
    cfg(8'h00, 32'h01000, 32'h00500, 32'h2, 32'h01, 32'h13);
    for (int i = 0; i < 4; i++) begin
      axi_wr(OFF_SEL, 32'h00000081, RESP_OKAY);
      wait_wr(i < 3 ? i + 1 : 3);
      if (i < 3) begin
        `CHK("src addr", 20'h01000 + 20'(2 * i), mem.rd_log[i])
        `CHK("dst addr", 20'h00500, mem.wa_log[i])
        `CHK("wdata", pat(20'h01000 + 20'(2 * i)), mem.wd_log[i])
        `CHK("word unit", 1'b1, rd_word)
      end
    end
    axi_rd(OFF_CTRL, 32'h00000012, RESP_OKAY);
    axi_rd(OFF_PTR, 32'h00001006, RESP_OKAY);
    axi_wr(OFF_SRC, 32'h00002000, RESP_OKAY);
    axi_wr(OFF_CTRL, 32'h00000013, RESP_OKAY);
    axi_wr(OFF_SEL, 32'h00000081, RESP_OKAY);
    wait_wr(4);
    `CHK("reload addr", 20'h02000, mem.rd_log[3])
  endtask : s_single

  task automatic s_repeat;
    lag <= 4'h3;
    // Destination-only increment, byte units, two units per run
    cfg(8'h20, 32'h00345, 32'h04000, 32'h1, 32'h02, 32'h25);
    for (int i = 0; i < 5; i++) begin
      pulse(0);
      wait_wr(5 + i);
      `CHK("dst addr", 20'h04000 + 20'(i), mem.wa_log[4 + i])
      `CHK("wdata", 16'h0045, mem.wd_log[4 + i])
      `CHK("byte unit", 1'b0, rd_word)
    end
    axi_rd(8'h20 | OFF_CTRL, 32'h00000025, RESP_OKAY);
    axi_wr(8'h20 | OFF_CTRL, 32'h00000024, RESP_OKAY);
    pulse(0);
    wait_wr(9);
  endtask : s_repeat

  task automatic s_prio;
    cfg(8'h00, 32'h00100, 32'h00200, 32'h0, 32'h02, 32'h05);
    cfg(8'h20, 32'h00700, 32'h00800, 32'h0, 32'h02, 32'h05);
    pulse(0);
    wait_wr(11);
    `CHK("first grant", 20'h00100, mem.rd_log[9])
    `CHK("second grant", 20'h00700, mem.rd_log[10])
    // Code ten maps to different sources on the two channels
    axi_wr(OFF_SEL, 32'h0000000A, RESP_OKAY);
    axi_wr(8'h20 | OFF_SEL, 32'h0000000A, RESP_OKAY);
    pulse(1);
    wait_wr(12);
    `CHK("sync port owner", 20'h00700, mem.rd_log[11])
    pulse(2);
    wait_wr(13);
    `CHK("uart owner", 20'h00100, mem.rd_log[12])
    // Extended bank, code six: both edges of line zero
    axi_wr(OFF_SEL, 32'h00000046, RESP_OKAY);
    for (int i = 0; i < 2; i++) begin
      @(posedge ref_clk_in);
      external_irq_line_zero_in <= i[0];
      wait_wr(14 + i);
      `CHK("edge owner", 20'h00100, mem.rd_log[13 + i])
    end
  endtask : s_prio

  always @(posedge ref_clk_in) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      results();
    end
  end

  initial begin
    ref_clk_in = 1'b0;
    forever #12.5 ref_clk_in = ~ref_clk_in;
  end

  initial begin
    rst_in = 1'b1;
    {s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in, s_axi_arvalid_in} = 4'h0;
    {s_axi_rready_in, adc_irq_in, sync_serial_port_three_irq_in} = 3'h0;
    sync_serial_port_four_irq_in = 1'b0;
    {external_irq_line_zero_in, external_irq_line_one_in} = 2'h3;
    {s_axi_awaddr_in, s_axi_araddr_in, s_axi_wdata_in} = 48'h0;
    s_axi_wstrb_in = 4'hF;
    lag = 4'h0;
    {timer_a_irq_in, timer_b_irq_in, uart_tx_irq_in, uart_rx_irq_in} = 14'h0;
    capture_compare_timer_irq_in = 9'h000;
    repeat (2) @(posedge ref_clk_in);
    rst_in <= 1'b0;
    s_regs();
    s_single();
    s_repeat();
    s_prio();
    results();
  end
endmodule : tb_top

/* testbench/tcd_bus_model.sv */
// Shared system bus and memory model facing the transfer engine
`timescale 1ns/1ps
module tcd_bus_model (
  input  wire logic        ref_clk_in,
  input  wire logic        rst_in,
  input  wire logic [3:0]  lag_in,
  input  wire logic        bus_req_in,
  output logic             bus_grant_out,
  input  wire logic [19:0] bus_addr_in,
  input  wire logic        bus_rd_in,
  input  wire logic        bus_wr_in,
  input  wire logic [15:0] bus_wdata_in,
  output logic [15:0]      bus_rdata_out,
  output logic             bus_ack_out
);
  logic [3:0]  wait_q;
  int          wr_cnt;
  int          rd_cnt;
  logic [19:0] rd_log [16];
  logic [19:0] wa_log [16];
  logic [15:0] wd_log [16];

  // Grants one cycle after the request, acks lag_in + 1 cycles after a read or write is raised
  always @(posedge ref_clk_in) begin
    bus_grant_out <= bus_req_in && !rst_in;
    bus_rdata_out <= ~bus_rdata_out;
    if (rst_in) begin
      bus_ack_out <= 1'b0;
      wait_q <= 4'h0;
      wr_cnt <= 0;
      rd_cnt <= 0;
    end else if (bus_ack_out) begin
      bus_ack_out <= 1'b0;
      wait_q <= 4'h0;
    end else if ((bus_rd_in || bus_wr_in) && wait_q < lag_in) begin
      wait_q <= wait_q + 4'h1;
    end else if (bus_rd_in) begin
      bus_ack_out <= 1'b1;
      bus_rdata_out <= {~bus_addr_in[7:0], bus_addr_in[7:0]};
      rd_log[rd_cnt[3:0]] <= bus_addr_in;
      rd_cnt <= rd_cnt + 1;
    end else if (bus_wr_in) begin
      bus_ack_out <= 1'b1;
      wa_log[wr_cnt[3:0]] <= bus_addr_in;
      wd_log[wr_cnt[3:0]] <= bus_wdata_in;
      wr_cnt <= wr_cnt + 1;
    end
  end
endmodule : tcd_bus_model
